// *** rtl/acr_adc_control.sv ***
// ----------------------------------------
// Overview of operation
// ----------------------------------------
// Overview of operation
// RULE1: standby without run: finish conversion then stop
// RULE2: standby run set: keep converting in standby
// RULE3: kind 0: positive input, unsigned result
// RULE4: kind 1: both inputs, signed result
// RULE5: left justify places result left in word
// RULE6: resolution 0 is 12 bit, 1 is 10
// RULE7: 12 bit 13.5 clocks, 10 bit 11.5
// RULE8: continuous mode restarts after each conversion
// RULE9: software start launches first continuous conversion
// RULE10: conversions only while enable bit set
// RULE11: accumulation code selects 1 to 128 samples
// RULE12: nonzero accumulation presents sum in result
// RULE13: prescaler divides peripheral clock, 2 to 256
// RULE14: delay register fields 7:5 and 3:0, reset zero
// RULE15: start bit reads one while converting
// RULE16: event rising edge starts a conversion
// RULE17: startup delay 0 to 256 clocks before first
// RULE18: window mode sets match flag by comparison
// RULE19: reserved codes fall back to defaults
// RULE20: 16 bit registers as low then high byte
`timescale 1ns/10ps
`include "acr_cfg.svh"
module acr_adc_control (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [7:0] dat_i,
   input wire logic sel_i,
   output logic [7:0] dat_o,
   output logic ack_o,
   // system
   input wire logic standby_i,
   input wire logic halted_i,
   input wire logic event_i,
   // analog core
   input wire logic [11:0] core_data_i,
   output acr_pkg::acr_core_req_type core_o,
   output logic result_ready_o
);
   acr_pkg::acr_state_type r;
   acr_pkg::acr_state_type next_r;

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic [8:0] div_of(input logic [3:0] c);
      unique case (c)
         4'h0: div_of = 9'd2;
         4'h1: div_of = 9'd4;
         4'h2: div_of = 9'd8;
         4'h3: div_of = 9'd12;
         4'h4: div_of = 9'd16;
         4'h5: div_of = 9'd20;
         4'h6: div_of = 9'd24;
         4'h7: div_of = 9'd28;
         4'h8: div_of = 9'd32;
         4'h9: div_of = 9'd48;
         4'ha: div_of = 9'd64;
         4'hb: div_of = 9'd96;
         4'hc: div_of = 9'd128;
         4'hd: div_of = 9'd256;
         default: div_of = 9'd2; // see RULE19
      endcase
   endfunction

   function automatic logic [8:0] init_of(input logic [2:0] c);
      unique case (c)
         3'h1: init_of = 9'd16;
         3'h2: init_of = 9'd32;
         3'h3: init_of = 9'd64;
         3'h4: init_of = 9'd128;
         3'h5: init_of = 9'd256;
         default: init_of = 9'd0; // see RULE19
      endcase
   endfunction

   function automatic logic [7:0] count_of(input logic [2:0] c);
      count_of = 8'h01 << c; // see RULE11
   endfunction

   logic [8:0] div_n;
   logic tick;
   logic res10;
   logic kind;
   logic running;
   logic bus_req;
   logic [15:0] sample_val;
   logic [15:0] new_sum;
   logic [15:0] shown;
   logic [9:0] conv_half;
   logic match;

   always_comb begin
      div_n = div_of(r.clock_divider_select[3:0]); // see RULE13
      tick = (r.div_cnt >= div_n - 9'd1);
      res10 = (r.control_a[`ACR_BIT_RES_LO +: 2] == 2'h1); // see RULE6
      kind = r.control_a[`ACR_BIT_KIND];
      // run in standby only with the standby bit; ongoing work completes
      running = r.control_a[`ACR_BIT_ENABLE] && !halted_i
         && (!standby_i || r.control_a[`ACR_BIT_STDBY] || r.busy); // see RULE1 RULE2 RULE10
      bus_req = cyc_i && stb_i && !r.ack;
      // 10-bit mode drops the two low core bits
      if (res10) begin
         sample_val = kind ? {{6{core_data_i[11]}}, core_data_i[11:2]}
            : {6'h00, core_data_i[11:2]}; // see RULE4 RULE3
      end else begin
         sample_val = kind ? {{4{core_data_i[11]}}, core_data_i}
            : {4'h0, core_data_i}; // see RULE4 RULE3
      end
      new_sum = r.acc_sum + sample_val; // see RULE12
      if (r.control_a[`ACR_BIT_LEFT]) begin
         shown = res10 ? {new_sum[9:0], 6'h00} : {new_sum[11:0], 4'h0}; // see RULE5
         if (r.acc[2:0] != 3'h0) begin
            shown = new_sum; // see RULE12
         end
      end else begin
         shown = new_sum;
      end
      // half-clock units: sampling length and base sampling time count twice
      conv_half = {1'b0, (res10 ? `ACR_CONV_HALF_10 : `ACR_CONV_HALF_12)}
         + {1'b0, r.sampling_extension, 1'b0} + {`ACR_SAMP_BASE, 1'b0}; // see RULE7
      unique case (r.win[2:0]) // see RULE18
         3'h1: match = kind ? ($signed(shown) < $signed(r.wlt)) : (shown < r.wlt);
         3'h2: match = kind ? ($signed(shown) > $signed(r.wht)) : (shown > r.wht);
         3'h3: match = kind ? ($signed(shown) >= $signed(r.wlt) && $signed(shown) <= $signed(r.wht))
            : (shown >= r.wlt && shown <= r.wht);
         3'h4: match = kind ? ($signed(shown) < $signed(r.wlt) || $signed(shown) > $signed(r.wht))
            : (shown < r.wlt || shown > r.wht);
         default: match = 1'b0;
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_r = r;
      next_r.ack = bus_req;
      next_r.ready_pulse = 1'b0;
      next_r.sample = 1'b0;
      next_r.ev_last = event_i;
      // prescaler, counts peripheral clocks while running, cleared otherwise
      if (running) begin
         next_r.div_cnt = tick ? 9'd0 : r.div_cnt + 9'd1;
      end else begin
         next_r.div_cnt = 9'd0;
      end
      if (!r.control_a[`ACR_BIT_ENABLE]) begin
         next_r.init_done = 1'b0;
      end
      // start requests
      if (event_i && !r.ev_last && r.event_input_control[0] && r.control_a[`ACR_BIT_ENABLE]) begin
         next_r.start_pend = 1'b1; // see RULE16
      end
      // sequencer
      unique case (r.phase)
         acr_pkg::ACR_IDLE: begin
            if (running && r.start_pend) begin // see RULE9
               next_r.start_pend = 1'b0;
               next_r.busy = 1'b1;
               next_r.acc_sum = 16'h0000;
               next_r.acc_left = count_of(r.acc[2:0]);
               next_r.sel_p = r.muxp[6:0];
               next_r.sel_n = r.muxn[6:0];
               next_r.tick_cnt = r.init_done ? 9'd0 : init_of(r.delay[7:5]); // see RULE17
               next_r.phase = acr_pkg::ACR_INIT;
            end
         end
         acr_pkg::ACR_INIT: begin
            next_r.init_done = 1'b1;
            if (r.tick_cnt == 9'd0) begin
               next_r.half_cnt = conv_half;
               next_r.sample = 1'b1;
               next_r.phase = acr_pkg::ACR_CONV;
            end else if (running && tick) begin
               next_r.tick_cnt = r.tick_cnt - 9'd1;
            end
         end
         acr_pkg::ACR_CONV: begin
            if (running && tick) begin
               next_r.half_cnt = (r.half_cnt > 10'd2) ? r.half_cnt - 10'd2 : 10'd0;
            end
            if (r.half_cnt == 10'd0) begin
               next_r.acc_sum = new_sum;
               next_r.acc_left = r.acc_left - 8'h01;
               if (r.acc_left == 8'h01) begin
                  next_r.res = shown;
                  next_r.ready_pulse = 1'b1;
                  next_r.irqfl[`ACR_BIT_READY] = 1'b1;
                  if (match) begin
                     next_r.irqfl[`ACR_BIT_WMATCH] = 1'b1;
                  end
                  next_r.busy = 1'b0; // see RULE15
                  if (r.control_a[`ACR_BIT_CONTINUOUS_CONVERSION]) begin
                     next_r.start_pend = 1'b1; // see RULE8
                  end
                  next_r.phase = acr_pkg::ACR_IDLE;
               end else begin
                  next_r.tick_cnt = {5'h00, r.delay[3:0]};
                  next_r.phase = acr_pkg::ACR_GAP;
               end
            end
         end
         acr_pkg::ACR_GAP: begin
            if (r.tick_cnt == 9'd0) begin
               next_r.half_cnt = conv_half;
               next_r.sample = 1'b1;
               next_r.phase = acr_pkg::ACR_CONV;
            end else if (running && tick) begin
               next_r.tick_cnt = r.tick_cnt - 9'd1;
            end
         end
         default: next_r.phase = acr_pkg::ACR_IDLE;
      endcase
      if (!r.control_a[`ACR_BIT_ENABLE]) begin
         next_r.phase = acr_pkg::ACR_IDLE; // see RULE10
         next_r.busy = 1'b0;
         next_r.start_pend = 1'b0;
      end
      // register reads
      unique case (adr_i)
         `ACR_OFF_CONTROL_A: next_r.rdat = r.control_a;
         `ACR_OFF_ACC: next_r.rdat = r.acc;
         `ACR_OFF_CLOCK_DIVIDER_SELECT: next_r.rdat = r.clock_divider_select;
         `ACR_OFF_DELAY: next_r.rdat = r.delay;
         `ACR_OFF_WIN: next_r.rdat = r.win;
         `ACR_OFF_SAMPLING_EXTENSION: next_r.rdat = r.sampling_extension;
         `ACR_OFF_MUXP: next_r.rdat = r.muxp;
         `ACR_OFF_MUXN: next_r.rdat = r.muxn;
         `ACR_OFF_CMD: next_r.rdat = {7'h00, r.busy | r.start_pend}; // see RULE15
         `ACR_OFF_EVENT_INPUT_CONTROL: next_r.rdat = r.event_input_control;
         `ACR_OFF_IRQEN: next_r.rdat = r.irqen;
         `ACR_OFF_IRQFL: next_r.rdat = r.irqfl;
         `ACR_OFF_HALT: next_r.rdat = r.halt;
         `ACR_OFF_SCRATCH: next_r.rdat = r.scratch;
         `ACR_OFF_RES_L: next_r.rdat = r.res[7:0]; // see RULE20
         `ACR_OFF_RES_H: next_r.rdat = r.res[15:8];
         `ACR_OFF_WLT_L: next_r.rdat = r.wlt[7:0];
         `ACR_OFF_WLT_H: next_r.rdat = r.wlt[15:8];
         `ACR_OFF_WHT_L: next_r.rdat = r.wht[7:0];
         `ACR_OFF_WHT_H: next_r.rdat = r.wht[15:8];
         default: next_r.rdat = 8'h00;
      endcase
      // register writes
      if (bus_req && we_i && sel_i) begin
         unique case (adr_i)
            `ACR_OFF_CONTROL_A: next_r.control_a = dat_i & 8'hbf;
            `ACR_OFF_ACC: next_r.acc = {5'h00, dat_i[2:0]};
            `ACR_OFF_CLOCK_DIVIDER_SELECT: next_r.clock_divider_select = {4'h0, dat_i[3:0]};
            `ACR_OFF_DELAY: next_r.delay = {dat_i[7:5], 1'b0, dat_i[3:0]}; // see RULE14
            `ACR_OFF_WIN: next_r.win = {5'h00, dat_i[2:0]};
            `ACR_OFF_SAMPLING_EXTENSION: next_r.sampling_extension = dat_i;
            `ACR_OFF_MUXP: next_r.muxp = {1'b0, dat_i[6:0]};
            `ACR_OFF_MUXN: next_r.muxn = {1'b0, dat_i[6:0]};
            `ACR_OFF_CMD: begin
               if (dat_i[`ACR_BIT_STOP]) begin
                  next_r.start_pend = 1'b0;
                  next_r.busy = 1'b0;
                  next_r.phase = acr_pkg::ACR_IDLE;
               end else if (dat_i[`ACR_BIT_START] && r.control_a[`ACR_BIT_ENABLE]) begin
                  next_r.start_pend = 1'b1; // see RULE9
               end
            end
            `ACR_OFF_EVENT_INPUT_CONTROL: next_r.event_input_control = {7'h00, dat_i[0]};
            `ACR_OFF_IRQEN: next_r.irqen = {6'h00, dat_i[1:0]};
            // flags clear on one, but a same-cycle set wins unless the flag was already set
            `ACR_OFF_IRQFL: next_r.irqfl = {6'h00, next_r.irqfl[1:0]
               & ~(dat_i[1:0] & ~(next_r.irqfl[1:0] & ~r.irqfl[1:0]))};
            `ACR_OFF_HALT: next_r.halt = {7'h00, dat_i[0]};
            `ACR_OFF_SCRATCH: next_r.scratch = dat_i;
            `ACR_OFF_WLT_L: next_r.wlt[7:0] = dat_i; // see RULE20
            `ACR_OFF_WLT_H: next_r.wlt[15:8] = dat_i;
            `ACR_OFF_WHT_L: next_r.wht[7:0] = dat_i;
            `ACR_OFF_WHT_H: next_r.wht[15:8] = dat_i;
            default: next_r.scratch = r.scratch;
         endcase
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign dat_o = r.rdat;
   assign ack_o = r.ack;
   assign result_ready_o = r.ready_pulse;
   assign core_o.pos_sel = r.sel_p;
   assign core_o.neg_sel = r.sel_n;
   assign core_o.two_input = r.control_a[`ACR_BIT_KIND]; // see RULE4
   assign core_o.sample = r.sample;
endmodule

// *** rtl/acr_cfg.svh ***
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH
// ----------------------------------------
// register offsets (byte index)
// ----------------------------------------
`define ACR_OFF_CONTROL_A 5'h00
`define ACR_OFF_ACC 5'h01
`define ACR_OFF_CLOCK_DIVIDER_SELECT 5'h02
`define ACR_OFF_DELAY 5'h03
`define ACR_OFF_WIN 5'h04
`define ACR_OFF_SAMPLING_EXTENSION 5'h05
`define ACR_OFF_MUXP 5'h08
`define ACR_OFF_MUXN 5'h09
`define ACR_OFF_CMD 5'h0a
`define ACR_OFF_EVENT_INPUT_CONTROL 5'h0b
`define ACR_OFF_IRQEN 5'h0c
`define ACR_OFF_IRQFL 5'h0d
`define ACR_OFF_HALT 5'h0e
`define ACR_OFF_SCRATCH 5'h0f
`define ACR_OFF_RES_L 5'h10
`define ACR_OFF_RES_H 5'h11
`define ACR_OFF_WLT_L 5'h12
`define ACR_OFF_WLT_H 5'h13
`define ACR_OFF_WHT_L 5'h14
`define ACR_OFF_WHT_H 5'h15
// ----------------------------------------
// field positions
// ----------------------------------------
`define ACR_BIT_ENABLE 0
`define ACR_BIT_CONTINUOUS_CONVERSION 1
`define ACR_BIT_RES_LO 2
`define ACR_BIT_LEFT 4
`define ACR_BIT_KIND 5
`define ACR_BIT_STDBY 7
`define ACR_BIT_START 0
`define ACR_BIT_STOP 1
`define ACR_BIT_READY 0
`define ACR_BIT_WMATCH 1
`define ACR_BIT_SDLY_LO 0
`define ACR_BIT_IDLY_LO 5
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define ACR_RST_BYTE 8'h00
`define ACR_RST_WORD 16'h0000
// conversion lengths in half converter clocks (13.5 and 11.5 cycles)
`define ACR_CONV_HALF_12 9'h01b
`define ACR_CONV_HALF_10 9'h017
// default sampling time in converter clocks
`define ACR_SAMP_BASE 9'h002
`endif

// *** rtl/acr_pkg.sv ***
package acr_pkg;
   typedef enum logic [2:0] {
      ACR_IDLE = 3'b000,
      ACR_INIT = 3'b001,
      ACR_CONV = 3'b011,
      ACR_GAP = 3'b010
   } acr_phase_type;

   typedef struct packed {
      logic [7:0] control_a;
      logic [7:0] acc;
      logic [7:0] clock_divider_select;
      logic [7:0] delay;
      logic [7:0] win;
      logic [7:0] sampling_extension;
      logic [7:0] muxp;
      logic [7:0] muxn;
      logic [7:0] event_input_control;
      logic [7:0] irqen;
      logic [7:0] irqfl;
      logic [7:0] halt;
      logic [7:0] scratch;
      logic [15:0] res;
      logic [15:0] wlt;
      logic [15:0] wht;
      logic start_pend;
      logic busy;
      logic ev_last;
      logic init_done;
      acr_phase_type phase;
      logic [8:0] div_cnt;
      logic [9:0] half_cnt;
      logic [8:0] tick_cnt;
      logic [15:0] acc_sum;
      logic [7:0] acc_left;
      logic [7:0] rdat;
      logic ack;
      logic ready_pulse;
      logic [6:0] sel_p;
      logic [6:0] sel_n;
      logic sample;
   } acr_state_type;

   typedef struct packed {
      logic [6:0] pos_sel;
      logic [6:0] neg_sel;
      logic two_input;
      logic sample;
   } acr_core_req_type;
endpackage

// *** sim/acr_core_model.sv ***
`timescale 1ns/10ps
module acr_core_model (
   // clock
   input wire logic clk_i,
   // core request side
   input wire acr_pkg::acr_core_req_type core_i,
   input wire logic [11:0] level_i,
   input wire logic clr_i,
   // sample data and bookkeeping
   output logic [11:0] core_data_o,
   output logic last_two_o,
   output logic [7:0] sample_count_o
);
   // ----------------------------------------
   // sampling core
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (clr_i) begin
         core_data_o <= ~level_i;
         last_two_o <= 1'b0;
         sample_count_o <= 8'h00;
      end else if (core_i.sample) begin
         core_data_o <= level_i;
         last_two_o <= core_i.two_input;
         sample_count_o <= sample_count_o + 8'h01;
      end
   end
endmodule

// *** sim/acr_adc_control_sva.sv ***
`timescale 1ns/10ps
module acr_adc_control_sva (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [7:0] dat_i,
   input wire logic sel_i,
   input wire logic [7:0] dat_o,
   input wire logic ack_o,
   // system and core
   input wire logic standby_i,
   input wire acr_pkg::acr_core_req_type core_o,
   input wire logic result_ready_o
);
   logic [7:0] control_a_sh;
   // ----------------------------------------
   // control shadow
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_a_sh <= 8'h00;
      end else if (ack_o && cyc_i && stb_i && we_i && sel_i && adr_i == 5'h00) begin
         control_a_sh <= dat_i;
      end
   end
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence bus_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence gap_read;
      bus_req ##0 !we_i && adr_i == 5'h06;
   endsequence
   sequence rdy_asleep;
      result_ready_o && standby_i && !control_a_sh[7];
   endsequence
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   ack_answer_a: assert property (bus_req |=> ack_o)
      else $error("no ack after request");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   gap_zero_a: assert property (gap_read ##1 ack_o |-> dat_o == 8'h00)
      else $error("unmapped read not zero");
   ready_pulse_a: assert property (result_ready_o |=> !result_ready_o)
      else $error("ready longer than one cycle");
   sample_pulse_a: assert property (core_o.sample |=> !core_o.sample)
      else $error("sample longer than one cycle");
   off_idle_a: assert property (!control_a_sh[0] [*3] |-> !core_o.sample && !result_ready_o)
      else $error("activity while disabled");
   kind_route_a: assert property (core_o.sample |-> core_o.two_input == control_a_sh[5])
      else $error("input kind mismatch");
   sleep_hold_a: assert property (rdy_asleep |=> (!core_o.sample || !standby_i) [*8])
      else $error("sample started in standby");
   reset_quiet_a: assert property ($fell(rst_i) |-> !ack_o && !result_ready_o && core_o == '0)
      else $error("outputs not idle after reset");
endmodule
bind acr_adc_control acr_adc_control_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o),
   .ack_o(ack_o), .standby_i(standby_i), .core_o(core_o), .result_ready_o(result_ready_o));

// *** sim/tb.sv ***
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, sel_i, standby_i, halted_i, event_i, ack_o, rdy, clr;
   logic [4:0] adr_i;
   logic [7:0] dat_i, dat_o, q, samples;
   logic [11:0] core_data_i, level;
   logic [15:0] e;
   logic last_two;
   acr_pkg::acr_core_req_type core_o;
   int bad_count = 0;
   int comparisons = 0;
   int n, p12, p10;
   acr_adc_control u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
      .standby_i(standby_i), .halted_i(halted_i), .event_i(event_i), .core_data_i(core_data_i),
      .core_o(core_o), .result_ready_o(rdy));
   acr_core_model u_model (.clk_i(clk_i), .core_i(core_o), .level_i(level), .clr_i(clr),
      .core_data_o(core_data_i), .last_two_o(last_two), .sample_count_o(samples));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task wrap_up;
      if (bad_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // bus and wait helpers
   // ----------------------------------------
   task wb(input logic w, input logic [4:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 100);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (k >= 100) bad_count++;
   endtask
   task rc(input logic [4:0] a, input logic [7:0] x);
      wb(1'b0, a, 8'h00);
      `CHK(q, x)
   endtask
   task wr(input int lim);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (rdy !== 1'b1 && n < lim);
   endtask
   task per(input logic [7:0] ca, input logic [7:0] pr, output int pd);
      wb(1'b1, 5'h02, pr);
      wb(1'b1, 5'h00, ca);
      wb(1'b1, 5'h0a, 8'h01);
      wr(900);
      wr(900);
      wr(900);
      pd = n;
      wb(1'b1, 5'h0a, 8'h02);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_regs;
      for (int a = 0; a < 16; a++)
         rc(a[4:0], 8'h00);
      wb(1'b1, 5'h03, 8'hef);
      rc(5'h03, 8'hef);
      wb(1'b1, 5'h13, 8'h01);
      rc(5'h13, 8'h01);
      rc(5'h12, 8'h00);
      wb(1'b1, 5'h10, 8'hff);
      rc(5'h10, 8'h00);
      wb(1'b1, 5'h03, 8'h00);
   endtask
   task t_single;
      wb(1'b1, 5'h15, 8'h01);
      wb(1'b1, 5'h04, 8'h02);
      wb(1'b1, 5'h08, 8'h45);
      wb(1'b1, 5'h09, 8'h48);
      wb(1'b1, 5'h00, 8'h01);
      wb(1'b1, 5'h0a, 8'h01);
      rc(5'h0a, 8'h01);
      wr(500);
      rc(5'h0a, 8'h00);
      rc(5'h10, 8'ha3);
      rc(5'h11, 8'h05);
      `CHK(last_two, 1'b0)
      `CHK(core_o.pos_sel, 7'h45)
      `CHK(core_o.neg_sel, 7'h48)
      wb(1'b0, 5'h0d, 8'h00);
      `CHK(q[1], 1'b1)
   endtask
   task t_res;
      per(8'h03, 8'h00, p12);
      per(8'h07, 8'h00, p10);
      `CHK(p12 - p10, 4)
      rc(5'h10, 8'h68);
      rc(5'h11, 8'h01);
      per(8'h03, 8'h01, p12);
      per(8'h07, 8'h01, p10);
      `CHK(p12 - p10, 8)
   endtask
   task t_acc;
      for (int c = 1; c < 4; c++) begin
         wb(1'b1, 5'h01, 8'(c));
         wb(1'b1, 5'h00, 8'h01);
         clr <= 1'b1;
         @(posedge clk_i);
         clr <= 1'b0;
         wb(1'b1, 5'h0a, 8'h01);
         wr(3000);
         e = {4'h0, level} << c;
         `CHK(samples, 8'h01 << c)
         rc(5'h10, e[7:0]);
         rc(5'h11, e[15:8]);
      end
      wb(1'b1, 5'h01, 8'h00);
      wb(1'b1, 5'h00, 8'h11);
      wb(1'b1, 5'h0a, 8'h01);
      wr(500);
      rc(5'h10, 8'h30);
      rc(5'h11, 8'h5a);
      wb(1'b1, 5'h00, 8'h21);
      wb(1'b1, 5'h0a, 8'h01);
      wr(500);
      `CHK(last_two, 1'b1)
   endtask
   task t_evt;
      wb(1'b1, 5'h00, 8'h01);
      wb(1'b1, 5'h0b, 8'h01);
      event_i <= 1'b1;
      wr(500);
      `CHK(n < 500, 1'b1)
      event_i <= 1'b0;
      wb(1'b1, 5'h0b, 8'h00);
      event_i <= 1'b1;
      wr(300);
      `CHK(n < 300, 1'b0)
      event_i <= 1'b0;
      wb(1'b1, 5'h00, 8'h00);
      wb(1'b1, 5'h0a, 8'h01);
      wr(300);
      `CHK(n < 300, 1'b0)
   endtask
   task t_sleep;
      wb(1'b1, 5'h00, 8'h03);
      wb(1'b1, 5'h0a, 8'h01);
      wr(500);
      standby_i <= 1'b1;
      wr(300);
      wr(300);
      `CHK(n < 300, 1'b0)
      wb(1'b1, 5'h00, 8'h83);
      wr(300);
      `CHK(n < 300, 1'b1)
      standby_i <= 1'b0;
      wb(1'b1, 5'h0a, 8'h02);
      wb(1'b1, 5'h00, 8'h00);
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 5'h00;
      dat_i = 8'h00;
      sel_i = 1'b1;
      standby_i = 1'b0;
      halted_i = 1'b0;
      event_i = 1'b0;
      level = 12'h5a3;
      clr = 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      clr <= 1'b0;
      t_regs;
      t_single;
      t_res;
      t_acc;
      t_evt;
      t_sleep;
      wrap_up;
   end
   initial begin
      repeat (60000) @(posedge clk_i);
      bad_count++;
      wrap_up;
   end
endmodule
